/* design/sac_top.sv */
// APPROX_REGISTER converter control: mode/channel registers, trigger, sequencer, result
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/100ps

module sac_top
  import sac_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RST_N,
  input  wire logic [9:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       HW_TRIGGER_IN,
  input  wire logic       CMP_IN,
  output logic      [2:0] ANALOG_INPUTS_SEL,
  output logic            SAMPLE,
  output logic            HOLD,
  output logic      [7:0] TAP_CODE,
  output logic            CONV_END_IRQ,
  output logic            BUSY
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  sac_st_t      st_r;
  sac_st_t      st_nxt;
  sac_bus_req_t req;
  logic [1:0]   edge_sel;
  logic [2:0]   time_sel;
  logic [7:0]   conv_len;
  logic         trig_rise;
  logic         trig_fall;
  logic         trig_hit;
  logic         enabled;
  logic         hw_mode;
  logic [7:0]   trial;

  assign req      = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign edge_sel = st_r.mode[SAC_EDGE_HI:SAC_EDGE_LO];
  assign time_sel = st_r.mode[SAC_TIME_HI:SAC_TIME_LO];
  assign enabled  = st_r.mode[SAC_EN_BIT];
  assign hw_mode  = st_r.mode[SAC_HW_BIT];

  // ----------------------------------------------------------------------------
  // Conversion length decode
  // ----------------------------------------------------------------------------
  always_comb begin
    case (time_sel)
      3'h0:    conv_len = SAC_LEN_000;
      3'h1:    conv_len = SAC_LEN_001;
      3'h2:    conv_len = SAC_LEN_010;
      3'h4:    conv_len = SAC_LEN_100;
      3'h5:    conv_len = SAC_LEN_101;
      3'h6:    conv_len = SAC_LEN_110;
      default: conv_len = SAC_LEN_000;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Trigger edge detection on agreeing second and third sync stages
  // ----------------------------------------------------------------------------
  assign trig_rise = st_r.trig_sync[1] & st_r.trig_sync[2] & ~st_r.trig_level;
  assign trig_fall = ~st_r.trig_sync[1] & ~st_r.trig_sync[2] & st_r.trig_level;
  always_comb begin
    case (edge_sel)
      SAC_EDGE_FALL: trig_hit = trig_fall;
      SAC_EDGE_RISE: trig_hit = trig_rise;
      SAC_EDGE_BOTH: trig_hit = trig_rise | trig_fall;
      default:       trig_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.irq   = 1'b0;
    st_nxt.rdata = 8'h00;
    trial        = 8'h00;

    st_nxt.trig_sync = {st_r.trig_sync[1:0], HW_TRIGGER_IN};
    if (st_r.trig_sync[1] == st_r.trig_sync[2]) begin
      st_nxt.trig_level = st_r.trig_sync[2];
    end

    // Register writes: bit writes arrive as full-byte read-modify-write
    if (req.wr) begin
      if (req.addr == SAC_MODE_ADDR) begin
        // Time field rewrites while enabled are taken as written, not guarded
        st_nxt.mode = req.wdata & SAC_MODE_WMASK;
      end else if (req.addr == SAC_CHAN_ADDR) begin
        st_nxt.chan = req.wdata[2:0];
      end
    end

    // Register reads, unmapped addresses return zero
    if (req.rd) begin
      case (req.addr)
        SAC_MODE_ADDR:   st_nxt.rdata = st_r.mode;
        SAC_CHAN_ADDR:   st_nxt.rdata = {5'h00, st_r.chan};
        SAC_RESULT_ADDR: st_nxt.rdata = st_r.result;
        default:         st_nxt.rdata = 8'h00;
      endcase
    end

    case (st_r.state)
      SAC_IDLE: begin
        st_nxt.sample = 1'b0;
        st_nxt.hold   = 1'b0;
        if (enabled && ((!hw_mode) || trig_hit)) begin
          st_nxt.state   = SAC_SAMPLE;
          st_nxt.cnt     = 8'h00;
          st_nxt.sample  = 1'b1;
          st_nxt.bit_len = (conv_len - SAC_SAMPLE_LEN) / SAC_BIT_DIV;
        end
      end
      SAC_SAMPLE: begin
        st_nxt.cnt = st_r.cnt + 8'h01;
        if (st_r.cnt == SAC_SAMPLE_LEN - 8'h01) begin
          st_nxt.state   = SAC_CONV;
          st_nxt.sample  = 1'b0;
          st_nxt.hold    = 1'b1;
          st_nxt.cnt     = 8'h00;
          st_nxt.bit_idx = 3'h7;
          st_nxt.approx  = 8'h80;
          st_nxt.tap     = 8'h80;
        end
      end
      SAC_CONV: begin
        st_nxt.cnt = st_r.cnt + 8'h01;
        if (st_r.cnt == st_r.bit_len - 8'h01) begin
          st_nxt.cnt = 8'h00;
          trial = st_r.approx;
          trial[st_r.bit_idx] = CMP_IN;
          st_nxt.approx = trial;
          if (st_r.bit_idx == 3'h0) begin
            st_nxt.state  = SAC_DONE;
            st_nxt.result = trial;
            st_nxt.irq    = 1'b1;
            st_nxt.hold   = 1'b0;
          end else begin
            st_nxt.bit_idx = st_r.bit_idx - 3'h1;
            trial[st_r.bit_idx - 3'h1] = 1'b1;
            st_nxt.approx = trial;
            st_nxt.tap    = trial;
          end
        end
      end
      SAC_DONE: begin
        // Hardware start rearms on the next edge; software start restarts
        st_nxt.state = SAC_IDLE;
      end
      default: st_nxt.state = SAC_IDLE;
    endcase

    // Clearing the enable bit stops a running conversion at once
    if (!enabled && st_r.state != SAC_DONE) begin
      st_nxt.state  = SAC_IDLE;
      st_nxt.sample = 1'b0;
      st_nxt.hold   = 1'b0;
    end

    // Busy is registered so that the output comes straight from a flop
    st_nxt.busy = st_nxt.sample | st_nxt.hold;
  end

  // ----------------------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r            <= '0;
      st_r.state      <= SAC_IDLE;
      st_r.mode       <= SAC_MODE_RST;
      st_r.chan       <= SAC_CHAN_RST[2:0];
      st_r.result     <= SAC_RESULT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA             = st_r.rdata;
  assign ANALOG_INPUTS_SEL = st_r.chan;
  assign SAMPLE            = st_r.sample;
  assign HOLD              = st_r.hold;
  assign TAP_CODE          = st_r.tap;
  assign CONV_END_IRQ      = st_r.irq;
  assign BUSY              = st_r.busy;

endmodule

/* design/sac_pkg.sv */
// Package: register map, field layout and timing for the APPROX_REGISTER converter control
package sac_pkg;

  // Register indices (printed offsets not all multiples of four)
  localparam logic [7:0] SAC_MODE_IDX   = 8'h80;
  localparam logic [7:0] SAC_CHAN_IDX   = 8'h81;
  localparam logic [7:0] SAC_RESULT_IDX = 8'h82;
  localparam logic [9:0] SAC_MODE_ADDR   = {SAC_MODE_IDX, 2'b00};
  localparam logic [9:0] SAC_CHAN_ADDR   = {SAC_CHAN_IDX, 2'b00};
  localparam logic [9:0] SAC_RESULT_ADDR = {SAC_RESULT_IDX, 2'b00};

  // Mode register field positions
  localparam int SAC_EN_BIT    = 7;
  localparam int SAC_HW_BIT    = 6;
  localparam int SAC_TIME_HI   = 5;
  localparam int SAC_TIME_LO   = 3;
  localparam int SAC_EDGE_HI   = 2;
  localparam int SAC_EDGE_LO   = 1;
  localparam logic [7:0] SAC_MODE_WMASK = 8'hfe;
  localparam logic [7:0] SAC_CHAN_WMASK = 8'h07;

  // Reset values
  localparam logic [7:0] SAC_MODE_RST   = 8'h00;
  localparam logic [7:0] SAC_CHAN_RST   = 8'h00;
  localparam logic [7:0] SAC_RESULT_RST = 8'h00;

  // Edge selection codes
  localparam logic [1:0] SAC_EDGE_NONE = 2'b00;
  localparam logic [1:0] SAC_EDGE_FALL = 2'b01;
  localparam logic [1:0] SAC_EDGE_RISE = 2'b10;
  localparam logic [1:0] SAC_EDGE_BOTH = 2'b11;

  // Conversion lengths in main clock cycles, per time code
  localparam logic [7:0] SAC_LEN_000 = 8'd144;
  localparam logic [7:0] SAC_LEN_001 = 8'd120;
  localparam logic [7:0] SAC_LEN_010 = 8'd96;
  localparam logic [7:0] SAC_LEN_100 = 8'd72;
  localparam logic [7:0] SAC_LEN_101 = 8'd60;
  localparam logic [7:0] SAC_LEN_110 = 8'd48;
  // Cycles of the conversion given to sampling before hold
  localparam logic [7:0] SAC_SAMPLE_LEN = 8'd16;
  // Number of bit decisions that share the cycles left after the sample phase
  localparam logic [7:0] SAC_BIT_DIV = 8'd8;

  typedef enum logic [1:0] {
    SAC_IDLE   = 2'b00,
    SAC_SAMPLE = 2'b01,
    SAC_CONV   = 2'b11,
    SAC_DONE   = 2'b10
  } sac_state_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sac_bus_req_t;

  typedef struct packed {
    sac_state_t  state;
    logic [7:0]  mode;
    logic [2:0]  chan;
    logic [7:0]  result;
    logic [7:0]  approx;
    logic [2:0]  bit_idx;
    logic [7:0]  cnt;
    logic [7:0]  bit_len;
    logic [2:0]  trig_sync;
    logic        trig_level;
    logic        sample;
    logic        hold;
    logic        irq;
    logic        busy;
    logic [7:0]  rdata;
    logic [7:0]  tap;
  } sac_st_t;

endpackage

/* verif/sac_afe_model.sv */
// Analog front end model: sample-hold, resistor ladder and comparator
`timescale 1ns/100ps
module sac_afe (
  input  wire logic       clk,
  input  wire logic [2:0] sel,
  input  wire logic       sample,
  input  wire logic [7:0] tap,
  output logic            cmp
);
  logic [7:0] held = 8'h00;
  // Each channel carries its own level, frozen once sampling ends
  // No digital port access is modelled during a conversion
  always @(posedge clk) begin
    if (sample) begin
      held <= {sel, 5'h0b};
    end
  end
  assign cmp = held >= tap;
endmodule

/* verif/sac_top_monitor.sv */
// Port assertions for the converter control
`timescale 1ns/100ps
module sac_top_monitor (
  input wire logic       REF_CLK,
  input wire logic       RST_N,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       SAMPLE,
  input wire logic       HOLD,
  input wire logic [7:0] TAP_CODE,
  input wire logic       CONV_END_IRQ,
  input wire logic       BUSY
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  chk_irq_pulse: assert property (CONV_END_IRQ |=> !CONV_END_IRQ)
    else $error("end pulse too long");
  chk_irq_at_end: assert property (CONV_END_IRQ |-> $fell(HOLD))
    else $error("end pulse without hold end");
  chk_sh_excl: assert property (!(SAMPLE && HOLD))
    else $error("sample and hold together");
  chk_busy_or: assert property (BUSY == (SAMPLE || HOLD))
    else $error("busy wrong");
  chk_msb_first: assert property ($rose(HOLD) |-> TAP_CODE == 8'h80)
    else $error("first trial not top bit");
  chk_sample_len: assert property ($rose(HOLD) |-> $past(SAMPLE, 16) && !$past(SAMPLE, 17))
    else $error("sample phase length wrong");
  chk_trial_bit: assert property (HOLD && $past(HOLD) && TAP_CODE != $past(TAP_CODE)
    |-> (TAP_CODE & ~$past(TAP_CODE)) != 8'h00) else $error("no new trial bit");
  chk_rd_quiet: assert property (RDATA != 8'h00 |-> $past(RD))
    else $error("read data outside read");
endmodule
bind sac_top sac_top_monitor sac_top_monitor_inst (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .RD(RD), .RDATA(RDATA), .SAMPLE(SAMPLE), .HOLD(HOLD), .TAP_CODE(TAP_CODE),
  .CONV_END_IRQ(CONV_END_IRQ), .BUSY(BUSY));

/* verif/test_sac_top.sv */
// Self-checking bench for the converter control
`timescale 1ns/100ps
module test_sac_top;
  import sac_pkg::*;
  logic       ref_clk, rst_n, wr, rd, trig, cmp, sample, hold, irq, busy, g;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, tap;
  logic [2:0] sel;
  int         n_mismatch = 0;
  int         n_checks = 0;
  sac_top sac_top_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .HW_TRIGGER_IN(trig), .CMP_IN(cmp),
    .ANALOG_INPUTS_SEL(sel), .SAMPLE(sample), .HOLD(hold), .TAP_CODE(tap),
    .CONV_END_IRQ(irq), .BUSY(busy));
  sac_afe sac_afe_inst (.clk(ref_clk), .sel(sel), .sample(sample), .tap(tap), .cmp(cmp));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic results;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(name, exp, rdata);
  endtask
  // Bounded wait for one end pulse, returns whether it came
  task automatic wait_irq(input int lim, output logic got);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge ref_clk);
      #1 got = (irq === 1'b1);
    end
  endtask
  // Whole run is under two thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    results;
  end
  initial begin
    {rst_n, wr, rd, trig, addr, wdata} = '0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(SAC_MODE_ADDR, 8'h00, "mode");
    rd_chk(SAC_CHAN_ADDR, 8'h00, "chan");
    rd_chk(SAC_RESULT_ADDR, 8'h00, "result");
    rd_chk(10'h3fc, 8'h00, "unmapped");
    wr_reg(SAC_RESULT_ADDR, 8'h5a);
    rd_chk(SAC_RESULT_ADDR, 8'h00, "result_ro");
    wr_reg(SAC_CHAN_ADDR, 8'h05);
    rd_chk(SAC_CHAN_ADDR, 8'h05, "chan");
    wr_reg(SAC_MODE_ADDR, 8'h80);
    rd_chk(SAC_MODE_ADDR, 8'h80, "mode");
    repeat (2) begin
      wait_irq(200, g);
      chk("soft_irq", 8'h01, {7'h00, g});
      rd_chk(SAC_RESULT_ADDR, {3'd5, 5'h0b}, "soft_result");
    end
    wr_reg(SAC_MODE_ADDR, 8'h00);
    wait_irq(300, g);
    chk("stopped_irq", 8'h00, {7'h00, g});
    wr_reg(SAC_CHAN_ADDR, 8'h03);
    for (int e = 0; e < 4; e++) begin
      wr_reg(SAC_MODE_ADDR, 8'hf0 | 8'(e << 1));
      repeat (2) begin
        @(posedge ref_clk);
        trig <= ~trig;
        wait_irq(100, g);
        chk("hw_irq", {7'h00, trig ? e[1] : e[0]}, {7'h00, g});
      end
    end
    rd_chk(SAC_RESULT_ADDR, {3'd3, 5'h0b}, "hw_result");
    results;
  end
endmodule
